// ===== verilog/cprs_top.sv
/*
  Clock, power and reset supervisor: APB register file, glitch-free
  master source switch, master divider, bus and USB clock enables,
  run/idle/sleep control, reset classes, reset cause, brown-out warning.
  Assumes every input is synchronous to mclk_in and that clock sources
  are slow enough to be sampled at 20 MHz.
*/
`timescale 1ns/1ps
`include "cprs_defs.svh"

module cprs_top #(
  parameter int NPERIPH = 8 // Number of gated peripherals
) (
  input wire logic mclk_in, // System clock, 20 MHz
  input wire logic reset_in, // Synchronous reset, active high
  input wire logic psel_in, // APB select
  input wire logic penable_in, // APB enable
  input wire logic pwrite_in, // APB write
  input wire logic [7:0] paddr_in, // APB byte address
  input wire logic [31:0] pwdata_in, // APB write data
  output logic [31:0] prdata_out, // APB read data
  output logic pready_out, // APB ready
  output logic pslverr_out, // APB error
  input wire logic osc_clk_in, // Main oscillator clock
  input wire logic pll_clk_in, // PLL clock
  input wire logic rtc_clk_in, // RTC oscillator clock
  input wire logic usb_ext_clock_pin_in, // External USB clock pin
  input wire logic irq_active_in, // Interrupt being serviced
  input wire logic wake_in, // Wake-up unit input
  input wire logic rtc_alarm_in, // RTC alarm
  input wire logic jtag_debug_in, // Debug session active
  input wire logic por_in, // Power-up condition
  input wire logic vdd_drop_in, // Core supply dropout
  input wire logic vddq_drop_in, // I/O supply dropout
  input wire logic wdg_timeout_in, // Watchdog timeout
  input wire logic ext_reset_pin_n_in, // External reset pin, low active
  input wire logic jtag_reset_cmd_in, // Debug reset command
  input wire logic [1:0] bo_warn_in, // Brown-out sag: {vddq, vdd}
  input wire logic vdd_below_lvd_in, // Core supply under threshold
  output logic mstr_clk_out, // Master clock
  output logic cpu_clk_en_out, // CPU clock enable pulse
  output logic flash_clk_en_out, // Flash interface enable pulse
  output logic hclk_en_out, // AHB clock enable pulse
  output logic bclk_en_out, // External bus enable pulse
  output logic [NPERIPH-1:0] periph_clk_on_out, // Peripheral gates
  output logic usb_clk_out, // USB clock
  output logic phy_clock_out_pin_out, // PHY clock pin
  output logic debug_return_clock_pin_out, // RTC calibration clock
  output logic pll_en_out, // PLL enable
  output logic osc_en_out, // Main oscillator input enable
  output logic global_reset_out, // Global reset class
  output logic system_reset_out, // System reset class
  output logic [NPERIPH-1:0] periph_reset_out, // Peripheral resets
  output logic brownout_irq_out, // Brown-out warning interrupt
  output logic sram_on_battery_out, // SRAM on battery supply
  output logic [1:0] mode_out // Current power mode
);

  // ===================================================================
  // Declarations
  cprs_pkg::cprs_mode_t mode_reg; // Power mode
  logic [9:0] clk_ctrl_reg; // Clock control settings
  logic [9:0] div_reg; // Master divisor minus one
  logic [NPERIPH-1:0] mask_reg; // Peripheral clock mask
  logic [NPERIPH-1:0] prst_reg; // Peripheral reset pulses
  logic [1:0] bo_mask_reg; // Brown-out interrupt enables
  logic [1:0] rst_stat_reg; // Reset cause flags
  logic [1:0] msrc_cur_reg; // Source now driving master
  logic park_reg; // Master held low while switching
  logic mstr_prev_reg; // Master level last cycle
  logic [9:0] div_cnt_reg; // Divider counter
  logic bclk_ph_reg; // Bus clock phase for halving
  logic usb_half_reg; // Divide-by-two USB clock
  logic global_evt; // Any global reset source
  logic sys_evt; // Any system reset source
  logic clk_clr; // Clock settings clear
  logic sys_clr; // System state clear
  logic wr_en; // APB write strobe
  logic setup; // APB setup phase
  logic mstr_rise; // Master rising edge
  logic rclk_tick; // Divided reference tick
  logic full_speed; // Speed-up active
  logic no_gate; // Debug holds clocks on
  logic src_level; // Current source level
  logic new_level; // Requested source level
  logic [1:0] msrc_req; // Requested source
  logic [31:0] rdata; // Read mux
  logic rerr; // Unmapped address

  // ===================================================================
  // Reset classes
  assign global_evt = reset_in | por_in | vdd_drop_in | vddq_drop_in;
  assign sys_evt = wdg_timeout_in | ~ext_reset_pin_n_in
                 | jtag_reset_cmd_in;
  // RQ16 settings survive
  assign clk_clr = global_evt;
  assign sys_clr = global_evt | sys_evt;
  assign setup = psel_in & ~penable_in;
  assign wr_en = psel_in & penable_in & pready_out & pwrite_in;
  assign no_gate = jtag_debug_in;
  assign msrc_req = clk_ctrl_reg[`CPRS_CC_MSRC_LSB +: 2];

  // RQ17 reset class outputs
  always_ff @(posedge mclk_in)
  begin
    global_reset_out <= global_evt;
    system_reset_out <= sys_clr;
  end

  // ===================================================================
  // Clock settings, cleared by global reset only
  // RQ1 RQ2 RQ7 settings
  always_ff @(posedge mclk_in)
  begin
    if (clk_clr)
    begin
      clk_ctrl_reg <= `CPRS_CC_RESET;
      div_reg <= `CPRS_DIV_RESET;
      mask_reg <= `CPRS_MASK_RESET;
    end
    else if (wr_en)
    begin
      // Accepted at any moment, also while running
      case (paddr_in)
        `CPRS_OFF_CLK_CTRL: clk_ctrl_reg <= pwdata_in[9:0];
        `CPRS_OFF_CLK_DIV: div_reg <= pwdata_in[9:0];
        `CPRS_OFF_CLK_MASK: mask_reg <= pwdata_in[NPERIPH-1:0];
        default:
        begin
          // Other registers are handled elsewhere
        end
      endcase
    end
  end

  // Brown-out mask, cleared by either reset class
  // RQ21 mask write
  always_ff @(posedge mclk_in)
  begin
    if (sys_clr)
      bo_mask_reg <= `CPRS_BO_RESET;
    else if (wr_en && paddr_in == `CPRS_OFF_BO_MASK)
      bo_mask_reg <= pwdata_in[1:0];
  end

  // Peripheral reset pulses, one cycle per written one
  // RQ19 single peripheral reset
  always_ff @(posedge mclk_in)
  begin
    if (sys_clr)
      prst_reg <= '0;
    else if (wr_en && paddr_in == `CPRS_OFF_PERIPH_RST)
      prst_reg <= pwdata_in[NPERIPH-1:0];
    else
      prst_reg <= '0;
  end
  assign periph_reset_out = prst_reg;

  // ===================================================================
  // Reset cause status, set wins over the power-up clear
  // RQ18 sticky cause
  always_ff @(posedge mclk_in)
  begin
    if (reset_in)
      rst_stat_reg <= 2'h0;
    else
    begin
      rst_stat_reg[`CPRS_RS_WDG] <= wdg_timeout_in
        | (rst_stat_reg[`CPRS_RS_WDG] & ~por_in);
      rst_stat_reg[`CPRS_RS_SUPPLY] <= vdd_drop_in | vddq_drop_in
        | (rst_stat_reg[`CPRS_RS_SUPPLY] & ~por_in);
    end
  end

  // ===================================================================
  // Power mode machine
  always_ff @(posedge mclk_in)
  begin
    // RQ8 reset enters run
    if (global_evt || ~ext_reset_pin_n_in || jtag_reset_cmd_in)
      mode_reg <= cprs_pkg::CPRS_RUN;
    else
    begin
      case (mode_reg)
        cprs_pkg::CPRS_RUN:
        begin
          // RQ10 idle bit entry
          if (wdg_timeout_in)
            mode_reg <= cprs_pkg::CPRS_RUN;
          else if (wr_en && paddr_in == `CPRS_OFF_PWR_CTRL &&
                   pwdata_in[`CPRS_PC_SLEEP])
            mode_reg <= cprs_pkg::CPRS_SLEEP;
          else if (wr_en && paddr_in == `CPRS_OFF_PWR_CTRL &&
                   pwdata_in[`CPRS_PC_IDLE])
            mode_reg <= cprs_pkg::CPRS_IDLE;
        end
        cprs_pkg::CPRS_IDLE:
        begin
          // RQ12 RQ24 exit clears idle bit
          if (irq_active_in || wake_in || wdg_timeout_in)
            mode_reg <= cprs_pkg::CPRS_RUN;
        end
        cprs_pkg::CPRS_SLEEP:
        begin
          // RQ14 watchdog ignored here
          if (rtc_alarm_in || wake_in)
            mode_reg <= cprs_pkg::CPRS_RUN;
        end
        default:
          mode_reg <= cprs_pkg::CPRS_RUN;
      endcase
    end
  end
  assign mode_out = mode_reg;

  // ===================================================================
  // Glitch-free master source switch
  always_comb
  begin
    case (msrc_cur_reg)
      cprs_pkg::CPRS_SRC_PLL: src_level = pll_clk_in;
      cprs_pkg::CPRS_SRC_RTC: src_level = rtc_clk_in;
      default: src_level = osc_clk_in;
    endcase
    case (msrc_req)
      cprs_pkg::CPRS_SRC_PLL: new_level = pll_clk_in;
      cprs_pkg::CPRS_SRC_RTC: new_level = rtc_clk_in;
      default: new_level = osc_clk_in;
    endcase
  end

  // RQ23 park low, then swap
  always_ff @(posedge mclk_in)
  begin
    if (clk_clr)
    begin
      msrc_cur_reg <= cprs_pkg::CPRS_SRC_OSC;
      park_reg <= 1'b0;
    end
    else if (!park_reg && msrc_req != msrc_cur_reg && !src_level)
      park_reg <= 1'b1;
    else if (park_reg && !new_level)
    begin
      msrc_cur_reg <= msrc_req;
      park_reg <= 1'b0;
    end
  end

  // Master output, stopped in sleep unless debug holds it
  // RQ13 sleep stops master
  always_ff @(posedge mclk_in)
  begin
    if (clk_clr)
      mstr_clk_out <= 1'b0;
    else
      mstr_clk_out <= src_level & ~park_reg
        & (mode_reg != cprs_pkg::CPRS_SLEEP || no_gate);
    mstr_prev_reg <= mstr_clk_out;
  end
  assign mstr_rise = mstr_clk_out & ~mstr_prev_reg;

  // ===================================================================
  // Reference divider, divisor div_reg+1 up to 1024
  // RQ9 speed-up bypass
  assign full_speed = clk_ctrl_reg[`CPRS_CC_SPEEDUP] & irq_active_in;
  assign rclk_tick = mstr_rise & (full_speed || div_cnt_reg == div_reg);

  // RQ6 dynamic divider
  always_ff @(posedge mclk_in)
  begin
    if (sys_clr || rclk_tick)
      div_cnt_reg <= 10'h000;
    else if (mstr_rise)
      div_cnt_reg <= div_cnt_reg + 10'h001;
  end

  // CPU, flash, AHB and bus clock enables
  always_ff @(posedge mclk_in)
  begin
    if (sys_clr)
    begin
      cpu_clk_en_out <= 1'b0;
      flash_clk_en_out <= 1'b0;
      hclk_en_out <= 1'b0;
      bclk_en_out <= 1'b0;
      bclk_ph_reg <= 1'b0;
    end
    else
    begin
      // RQ10 RQ15 CPU stops unless debug
      cpu_clk_en_out <= rclk_tick
        & (mode_reg == cprs_pkg::CPRS_RUN || no_gate);
      flash_clk_en_out <= rclk_tick
        & (mode_reg == cprs_pkg::CPRS_RUN || no_gate);
      hclk_en_out <= rclk_tick;
      if (rclk_tick)
        bclk_ph_reg <= ~bclk_ph_reg;
      // RQ1 bus clock ratio
      bclk_en_out <= rclk_tick
        & (~clk_ctrl_reg[`CPRS_CC_EMI_HALF] | bclk_ph_reg);
    end
  end

  // Peripheral gates follow the mask in run and idle
  // RQ11 RQ15 peripheral gating
  always_ff @(posedge mclk_in)
  begin
    if (sys_clr)
      periph_clk_on_out <= '0;
    else if (no_gate)
      periph_clk_on_out <= '1;
    else if (mode_reg == cprs_pkg::CPRS_SLEEP)
      periph_clk_on_out <= '0;
    else
      periph_clk_on_out <= mask_reg;
  end

  // ===================================================================
  // USB, PHY and calibration clocks
  // RQ3 divide-by-two stage
  always_ff @(posedge mclk_in)
  begin
    if (sys_clr)
      usb_half_reg <= 1'b0;
    else if (mstr_rise)
      usb_half_reg <= ~usb_half_reg;
  end

  // RQ2 USB source select
  always_ff @(posedge mclk_in)
  begin
    if (sys_clr)
      usb_clk_out <= 1'b0;
    else
    begin
      case (clk_ctrl_reg[`CPRS_CC_USB_LSB +: 2])
        cprs_pkg::CPRS_USB_HALF: usb_clk_out <= usb_half_reg;
        cprs_pkg::CPRS_USB_PIN: usb_clk_out <= usb_ext_clock_pin_in;
        default: usb_clk_out <= mstr_clk_out;
      endcase
    end
  end

  // RQ4 RQ5 PHY and calibration outputs
  always_ff @(posedge mclk_in)
  begin
    if (clk_clr)
    begin
      phy_clock_out_pin_out <= 1'b0;
      debug_return_clock_pin_out <= 1'b0;
    end
    else
    begin
      phy_clock_out_pin_out <= osc_clk_in & osc_en_out
        & clk_ctrl_reg[`CPRS_CC_PHY_EN];
      debug_return_clock_pin_out <= rtc_clk_in
        & clk_ctrl_reg[`CPRS_CC_RTC_OUT];
    end
  end

  // ===================================================================
  // Oscillator, PLL, detector outputs
  // RQ13 oscillator and PLL off
  always_ff @(posedge mclk_in)
  begin
    if (clk_clr)
    begin
      osc_en_out <= 1'b1;
      pll_en_out <= 1'b0;
    end
    else
    begin
      osc_en_out <= mode_reg != cprs_pkg::CPRS_SLEEP || no_gate;
      pll_en_out <= clk_ctrl_reg[`CPRS_CC_PLL_EN]
        & (mode_reg != cprs_pkg::CPRS_SLEEP || no_gate);
    end
  end

  // RQ20 RQ21 RQ22 warning and battery
  always_ff @(posedge mclk_in)
  begin
    if (sys_clr)
      brownout_irq_out <= 1'b0;
    else
      brownout_irq_out <= |(bo_warn_in & bo_mask_reg);
    if (clk_clr)
      sram_on_battery_out <= 1'b0;
    else
      sram_on_battery_out <= vdd_below_lvd_in
        & clk_ctrl_reg[`CPRS_CC_LVD_EN];
  end

  // ===================================================================
  // APB read side, zero-wait answers
  always_comb
  begin
    rdata = 32'h0000_0000;
    rerr = 1'b0;
    case (paddr_in)
      `CPRS_OFF_CLK_CTRL: rdata[9:0] = clk_ctrl_reg;
      `CPRS_OFF_CLK_DIV: rdata[9:0] = div_reg;
      `CPRS_OFF_CLK_MASK: rdata[NPERIPH-1:0] = mask_reg;
      `CPRS_OFF_PWR_CTRL:
        rdata[1:0] = {mode_reg == cprs_pkg::CPRS_SLEEP,
                      mode_reg == cprs_pkg::CPRS_IDLE};
      `CPRS_OFF_RST_STAT: rdata[1:0] = rst_stat_reg;
      `CPRS_OFF_PERIPH_RST: rdata = 32'h0000_0000;
      `CPRS_OFF_BO_MASK: rdata[1:0] = bo_mask_reg;
      `CPRS_OFF_STATUS:
        rdata[6:0] = {bo_warn_in, park_reg, msrc_cur_reg, mode_reg};
      default: rerr = 1'b1;
    endcase
  end

  // Answer registered in setup, shown in access
  always_ff @(posedge mclk_in)
  begin
    if (reset_in)
    begin
      pready_out <= 1'b0;
      prdata_out <= 32'h0000_0000;
      pslverr_out <= 1'b0;
    end
    else
    begin
      pready_out <= setup;
      prdata_out <= (setup && !pwrite_in) ? rdata : 32'h0000_0000;
      pslverr_out <= setup & rerr;
    end
  end

  // ===================================================================
  // Assertions
  // RQ10 CPU stops
  AST_IDLE_STOPS_CPU: assert property (@(posedge mclk_in) // RQ10
    disable iff (reset_in) (mode_reg != cprs_pkg::CPRS_RUN && !no_gate)
    |=> !cpu_clk_en_out) else $error("CPU clock runs outside run");
  // RQ12 idle exit
  AST_IDLE_EXIT: assert property (@(posedge mclk_in) // RQ12
    disable iff (reset_in)
    (mode_reg == cprs_pkg::CPRS_IDLE && (irq_active_in || wake_in))
    |=> mode_reg == cprs_pkg::CPRS_RUN) else $error("Idle not left");
  AST_SLEEP_WDG_STAYS: assert property (@(posedge mclk_in) // RQ14
    disable iff (reset_in)
    (mode_reg == cprs_pkg::CPRS_SLEEP && wdg_timeout_in && !rtc_alarm_in
     && !wake_in && !global_evt && ext_reset_pin_n_in
     && !jtag_reset_cmd_in) |=> mode_reg == cprs_pkg::CPRS_SLEEP)
    else $error("Watchdog left sleep");
  AST_SLEEP_PLL_OFF: assert property (@(posedge mclk_in) // RQ13
    disable iff (reset_in)
    (mode_reg == cprs_pkg::CPRS_SLEEP && !no_gate) [*2] |->
    !pll_en_out && !osc_en_out && !mstr_clk_out)
    else $error("Clock alive in sleep");
  AST_DEBUG_NO_GATE: assert property (@(posedge mclk_in) // RQ15
    disable iff (reset_in || sys_clr) no_gate |=> &periph_clk_on_out)
    else $error("Clock gated during debug");
  AST_BO_MASKED: assert property (@(posedge mclk_in) // RQ21
    disable iff (reset_in) (bo_mask_reg == 2'h0) |=> !brownout_irq_out)
    else $error("Masked brown-out raised");
  AST_SRAM_BATT: assert property (@(posedge mclk_in) // RQ22
    disable iff (reset_in)
    (vdd_below_lvd_in && clk_ctrl_reg[`CPRS_CC_LVD_EN] && !clk_clr)
    |=> sram_on_battery_out) else $error("SRAM not on battery");
  AST_CAUSE_STICKY: assert property (@(posedge mclk_in) // RQ18
    disable iff (reset_in) (rst_stat_reg[`CPRS_RS_WDG] && !por_in)
    |=> rst_stat_reg[`CPRS_RS_WDG]) else $error("Cause flag lost");
  AST_GLOBAL_CLASS: assert property (@(posedge mclk_in) // RQ17
    disable iff (reset_in) (vdd_drop_in || vddq_drop_in || por_in)
    |=> global_reset_out && system_reset_out)
    else $error("Supply fault missed global reset");
  AST_SPEEDUP: assert property (@(posedge mclk_in) // RQ9
    disable iff (reset_in || sys_clr)
    (full_speed && mstr_rise && mode_reg == cprs_pkg::CPRS_RUN)
    |=> cpu_clk_en_out) else $error("No full speed in interrupt");
  COV_IDLE_ROUND: cover property (@(posedge mclk_in)
    mode_reg == cprs_pkg::CPRS_IDLE ##1 mode_reg == cprs_pkg::CPRS_RUN);
  COV_SLEEP_WAKE: cover property (@(posedge mclk_in)
    mode_reg == cprs_pkg::CPRS_SLEEP && rtc_alarm_in);
  COV_SRC_SWITCH: cover property (@(posedge mclk_in)
    park_reg ##1 !park_reg);

endmodule // cprs_top

// ===== verilog/cprs_defs.svh
/*
  Constants of the clock, power and reset supervisor: register offsets,
  field positions, reset values and timing figures.
  Assumes it is included by its bare name from the top and the bench.
*/
// Functional notes
// RQ1: Bus clock equals or halves the AHB clock
// RQ2: USB clock picked from three firmware sources
// RQ3: Optional divide-by-two gives USB 48 MHz
// RQ4: Main oscillator forwarded to PHY clock pin
// RQ5: RTC clock on debug pin, runs in sleep
// RQ6: Master clock divisible by up to 1024
// RQ7: Master source may switch to RTC anytime
// RQ8: Every reset returns to run mode; a watchdog timeout in sleep leaves the mode at sleep
// RQ9: Interrupt speed-up runs CPU at full rate
// RQ10: Idle bit stops CPU and flash clocks
// RQ11: Idle keeps peripheral clocks per mask
// RQ12: Reset, interrupt or wake-up leaves idle
// RQ13: Sleep stops clocks, oscillator off, PLL off
// RQ14: Sleep exits on resets, alarm, wake; not watchdog
// RQ15: Debug active means no clock gated off
// RQ16: System reset keeps clock settings and status
// RQ17: Supply faults global; watchdog, pin, debug system
// RQ18: Reset cause sticky, cleared by power-up only
// RQ19: Firmware resets single peripherals anytime
// RQ20: Supply sag raises brown-out warning interrupt
// RQ21: Brown-out interrupts maskable by firmware
// RQ22: SRAM moves to battery under detector threshold
// RQ23: Master source switch never glitches
// RQ24: Idle bit clears itself on idle exit
`ifndef CPRS_DEFS_SVH
`define CPRS_DEFS_SVH

// =====================================================================
// Register offsets (byte addresses)
`define CPRS_OFF_CLK_CTRL 8'h00
`define CPRS_OFF_CLK_DIV 8'h04
`define CPRS_OFF_CLK_MASK 8'h08
`define CPRS_OFF_PWR_CTRL 8'h0c
`define CPRS_OFF_RST_STAT 8'h10
`define CPRS_OFF_PERIPH_RST 8'h14
`define CPRS_OFF_BO_MASK 8'h18
`define CPRS_OFF_STATUS 8'h1c

// =====================================================================
// Clock control fields
`define CPRS_CC_MSRC_LSB 0
`define CPRS_CC_EMI_HALF 2
`define CPRS_CC_USB_LSB 3
`define CPRS_CC_PHY_EN 5
`define CPRS_CC_RTC_OUT 6
`define CPRS_CC_SPEEDUP 7
`define CPRS_CC_PLL_EN 8
`define CPRS_CC_LVD_EN 9
`define CPRS_CC_RESET 10'h200

// Power control and reset status fields
`define CPRS_PC_IDLE 0
`define CPRS_PC_SLEEP 1
`define CPRS_RS_WDG 0
`define CPRS_RS_SUPPLY 1

// Reset values
`define CPRS_DIV_RESET 10'h000
`define CPRS_MASK_RESET 8'hff
`define CPRS_BO_RESET 2'h0

// =====================================================================
// Timing figures
`define CPRS_MCLK_HZ 20000000
`define CPRS_DIV_MAX 1024

`endif

// ===== verilog/cprs_pkg.sv
/*
  Types of the clock, power and reset supervisor.
  Assumes nothing; users write cprs_pkg::name.
*/
package cprs_pkg;

  // Global power modes, Gray coded along run-idle-sleep
  typedef enum logic [1:0]
  {
    CPRS_RUN = 2'h0,
    CPRS_IDLE = 2'h1,
    CPRS_SLEEP = 2'h3
  } cprs_mode_t;

  // Master clock sources
  typedef enum logic [1:0]
  {
    CPRS_SRC_OSC = 2'h0,
    CPRS_SRC_PLL = 2'h1,
    CPRS_SRC_RTC = 2'h2
  } cprs_src_t;

  // USB clock sources
  typedef enum logic [1:0]
  {
    CPRS_USB_MSTR = 2'h0,
    CPRS_USB_HALF = 2'h1,
    CPRS_USB_PIN = 2'h2
  } cprs_usb_t;

endpackage : cprs_pkg

// ===== sim/tb_top.sv
/*
  Self-checking bench of the clock, power and reset supervisor.
  Assumes the design files under verilog/ are compiled first.
*/
`timescale 1ns/1ps
`include "cprs_defs.svh"

module tb_top;
  // ==========================================================
  // Stimulus, observed outputs and bookkeeping
  logic mclk_in = 1'b0; // System clock, 50 ns
  logic reset_in = 1'b1; // Power-up reset
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0; // APB controls
  logic [7:0] paddr = 8'h00; // APB address
  logic [31:0] pwdata = 32'h0; // APB write data
  logic [4:0] evt = 5'h0; // Events: vdd drop, wdg, alarm, wake, irq
  logic [1:0] bo_warn = 2'h0; // Brown-out sag inputs
  logic below = 1'b0; // Core supply under threshold
  logic dbg = 1'b0; // Debug session active
  logic [7:0] pclk_on, prst; // Peripheral gates and resets
  logic [3:0] cnt = 4'h0; // Source clock pattern
  logic [31:0] prdata; // Read data
  logic pready, pslverr, pll_en, osc_en, bo_irq, sram_bat, cpu_en;
  logic [1:0] mode; // Power mode
  logic [32:0] exp_q[$]; // Expected {pslverr, prdata}
  logic [32:0] msk_q[$]; // Bits that count
  int mismatches = 0; // Failed comparisons
  int compares = 0; // All comparisons
  int seed = 82539; // Random seed
  logic [31:0] v; // Random register value

  // Clock and slow source clocks
  always #25 mclk_in = ~mclk_in;
  always @(posedge mclk_in) cnt <= cnt + 4'h1;

  cprs_top dut (
    .mclk_in(mclk_in), .reset_in(reset_in), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
    .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
    .pslverr_out(pslverr), .osc_clk_in(cnt[1]), .pll_clk_in(cnt[0]),
    .rtc_clk_in(cnt[3]), .usb_ext_clock_pin_in(cnt[2]),
    .irq_active_in(evt[0]), .wake_in(evt[1]), .rtc_alarm_in(evt[2]),
    .jtag_debug_in(dbg), .por_in(1'b0), .vdd_drop_in(evt[4]),
    .vddq_drop_in(1'b0), .wdg_timeout_in(evt[3]),
    .ext_reset_pin_n_in(1'b1), .jtag_reset_cmd_in(1'b0),
    .bo_warn_in(bo_warn), .vdd_below_lvd_in(below), .mstr_clk_out(),
    .cpu_clk_en_out(cpu_en), .flash_clk_en_out(), .hclk_en_out(),
    .bclk_en_out(), .periph_clk_on_out(pclk_on), .usb_clk_out(),
    .phy_clock_out_pin_out(), .debug_return_clock_pin_out(),
    .pll_en_out(pll_en), .osc_en_out(osc_en), .global_reset_out(),
    .system_reset_out(), .periph_reset_out(prst),
    .brownout_irq_out(bo_irq), .sram_on_battery_out(sram_bat),
    .mode_out(mode));

  // ==========================================================
  // Tasks
  task automatic report_and_stop;
    begin
      mismatches += exp_q.size();
      $display("Counts: %0d compares, %0d mismatches", compares, mismatches);
      if (mismatches == 0 && compares > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask

  // One APB transfer; the expectation is queued for the monitor
  task automatic apb(input logic wr, input logic [7:0] a,
    input logic [31:0] d, input logic [32:0] e, input logic [32:0] m);
    begin
      exp_q.push_back(e);
      msk_q.push_back(m);
      @(posedge mclk_in);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk_in);
      penable <= 1'b1;
      // Request held until pready is seen high at a rising edge
      @(posedge mclk_in);
      while (pready !== 1'b1)
        @(posedge mclk_in);
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  // Write must be accepted without error
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 33'h0, {1'b1, 32'h0});
  endtask

  // Read expects value and error flag
  task automatic rd(input logic [7:0] a, input logic [31:0] d,
    input logic err = 1'b0);
    apb(1'b0, a, 32'h0, {err, d}, {33{1'b1}});
  endtask

  // Pulse one event input, then let it settle
  task automatic pulse(input int i);
    begin
      @(posedge mclk_in);
      evt[i] <= 1'b1;
      @(posedge mclk_in);
      evt[i] <= 1'b0;
      repeat (4) @(posedge mclk_in);
      @(negedge mclk_in);
    end
  endtask

  // Compare a level output
  task automatic check_lvl(input logic [1:0] g, input logic [1:0] e);
    begin
      compares++;
      if (g !== e)
      begin
        mismatches++;
        $display("[FAIL] %0t got %h exp %h", $time, g, e);
      end
    end
  endtask

  // Compare transfer answers, oldest expectation first
  always @(negedge mclk_in)
  begin
    if (pready === 1'b1)
    begin
      compares++;
      if (({pslverr, prdata} & msk_q[0]) !== (exp_q[0] & msk_q[0]))
      begin
        mismatches++;
        $display("[FAIL] %0t got %h exp %h", $time,
          {pslverr, prdata}, exp_q[0]);
      end
      void'(exp_q.pop_front());
      void'(msk_q.pop_front());
    end
  end

  // Watchdog against hangs
  initial
  begin
    repeat (20000) @(posedge mclk_in);
    mismatches++;
    report_and_stop();
  end

  // ==========================================================
  // Main sequence
  initial
  begin
    repeat (10) @(posedge mclk_in);
    reset_in <= 1'b0;
    @(negedge mclk_in);
    check_lvl(mode, 2'h0);
    rd(`CPRS_OFF_CLK_CTRL, 32'h200);
    rd(`CPRS_OFF_CLK_MASK, 32'hff);
    rd(`CPRS_OFF_BO_MASK, 32'h0);
    rd(8'h20, 32'h0, 1'b1);
    for (int i = 0; i < 3; i++)
    begin
      v = $random(seed) & 32'h3ff;
      wr(`CPRS_OFF_CLK_DIV, v);
      rd(`CPRS_OFF_CLK_DIV, v);
    end
    wr(`CPRS_OFF_PERIPH_RST, 32'h5a);
    @(negedge mclk_in);
    check_lvl({prst == 8'h5a, &pclk_on}, 2'h3);
    @(negedge mclk_in);
    check_lvl({prst == 8'h00, &pclk_on}, 2'h3);
    $display("Test 1 done: reset values and divider");
    wr(`CPRS_OFF_PWR_CTRL, 32'h1);
    @(negedge mclk_in);
    check_lvl(mode, 2'h1);
    repeat (6) @(negedge mclk_in);
    check_lvl({1'b0, cpu_en}, 2'h0);
    pulse(0);
    check_lvl(mode, 2'h0);
    rd(`CPRS_OFF_PWR_CTRL, 32'h0);
    $display("Test 2 done: idle entry and exit");
    wr(`CPRS_OFF_CLK_CTRL, 32'h380);
    for (int i = 1; i < 3; i++)
    begin
      wr(`CPRS_OFF_PWR_CTRL, 32'h2);
      pulse(3);
      check_lvl(mode, 2'h3);
      check_lvl({pll_en | osc_en, |pclk_on}, 2'h0);
      pulse(i);
      check_lvl(mode, 2'h0);
    end
    // Debug session in sleep keeps every clock running
    wr(`CPRS_OFF_PWR_CTRL, 32'h2);
    dbg <= 1'b1;
    repeat (3) @(negedge mclk_in);
    check_lvl({osc_en, &pclk_on}, 2'h3);
    @(posedge mclk_in);
    dbg <= 1'b0;
    pulse(1);
    check_lvl(mode, 2'h0);
    $display("Test 3 done: sleep entry and exit");
    wr(`CPRS_OFF_BO_MASK, 32'h3);
    pulse(3);
    rd(`CPRS_OFF_CLK_CTRL, 32'h380);
    // Interrupt held in run with speed-up enabled
    evt[0] <= 1'b1;
    rd(`CPRS_OFF_BO_MASK, 32'h0);
    rd(`CPRS_OFF_RST_STAT, 32'h1);
    evt[0] <= 1'b0;
    pulse(4);
    rd(`CPRS_OFF_CLK_CTRL, 32'h200);
    rd(`CPRS_OFF_RST_STAT, 32'h3);
    @(posedge mclk_in);
    reset_in <= 1'b1;
    repeat (2) @(posedge mclk_in);
    reset_in <= 1'b0;
    rd(`CPRS_OFF_RST_STAT, 32'h0);
    $display("Test 4 done: reset classes and cause");
    bo_warn <= 2'h1;
    below <= 1'b1;
    repeat (3) @(negedge mclk_in);
    check_lvl({sram_bat, bo_irq}, 2'h2);
    wr(`CPRS_OFF_BO_MASK, 32'h3);
    wr(`CPRS_OFF_CLK_CTRL, 32'h0);
    repeat (3) @(negedge mclk_in);
    check_lvl({sram_bat, bo_irq}, 2'h1);
    $display("Test 5 done: brown-out and battery");
    report_and_stop();
  end
endmodule // tb_top
